// file: shared/ffac_params.svh
`ifndef FFAC_PARAMS_SVH
`define FFAC_PARAMS_SVH

// register indices, byte address is four times the index
`define FFAC_IDX_FRAME_OPTIONS 10'h048
`define FFAC_IDX_FRAME_CONTENT 10'h049
`define FFAC_IDX_TARGET_ADDRESS 10'h04b
`define FFAC_IDX_PORT_SETUP 10'h04c
`define FFAC_IDX_READ_POINTER 10'h04d
`define FFAC_IDX_WRITE_POINTER 10'h04e
`define FFAC_IDX_WRITE_BYTE 10'h04f
`define FFAC_IDX_POLL_SETUP 10'h044
`define FFAC_IDX_PORT_STATUS 10'h060

// reset values
`define FFAC_RST_FRAME_OPTIONS 8'h02
`define FFAC_RST_FRAME_CONTENT 8'h10
`define FFAC_RST_TARGET_ADDRESS 8'h20
`define FFAC_RST_PORT_SETUP 8'h83
`define FFAC_RST_READ_POINTER 8'h42
`define FFAC_RST_WRITE_POINTER 8'h4c
`define FFAC_RST_WRITE_BYTE 8'h02
`define FFAC_RST_POLL_SETUP 8'h46

// writable bits, reserved bits read as zero
`define FFAC_MASK_FRAME_OPTIONS 8'h03
`define FFAC_MASK_FRAME_CONTENT 8'h7c
`define FFAC_MASK_TARGET_ADDRESS 8'hfe
`define FFAC_MASK_PORT_SETUP 8'h83
`define FFAC_MASK_FULL 8'hff

// field positions
`define FFAC_BIT_STOP_ON_FULL 0
`define FFAC_BIT_TIME_EN 1
`define FFAC_BIT_TAG_TWO 2
`define FFAC_BIT_TAG_ONE 3
`define FFAC_BIT_HEADER_EN 4
`define FFAC_BIT_AUX_EN 5
`define FFAC_BIT_ACC_EN 6
`define FFAC_BIT_MANUAL 7
`define FFAC_BIT_ST_BUSY 0
`define FFAC_BIT_ST_NACK 1
`define FFAC_BIT_ST_PEND 2

// burst lengths per code
`define FFAC_BURST_L0 4'h1
`define FFAC_BURST_L1 4'h2
`define FFAC_BURST_L2 4'h6
`define FFAC_BURST_L3 4'h8

// poll rate codes, fastest code has the base period
`define FFAC_ODR_MIN 4'h1
`define FFAC_ODR_MAX 4'hb

// timing
`define FFAC_PCLK_HZ 125000000
`define FFAC_SCL_HZ 400000
`define FFAC_QUARTER_CYCLES \
	((`FFAC_PCLK_HZ + 4 * `FFAC_SCL_HZ - 1) / (4 * `FFAC_SCL_HZ))
`define FFAC_POLL_BASE_US 1250
`define FFAC_POLL_BASE_CYCLES \
	(`FFAC_POLL_BASE_US * (`FFAC_PCLK_HZ / 1000000))

`endif

// file: shared/ffac_pkg.sv
package ffac_pkg;

	typedef enum logic [1:0] {
		ffac_op_start = 2'h0,
		ffac_op_stop = 2'h1,
		ffac_op_byte = 2'h2
	} ffac_op_t;

	typedef enum logic [1:0] {
		ffac_b_idle = 2'h0,
		ffac_b_start = 2'h1,
		ffac_b_stop = 2'h2,
		ffac_b_bits = 2'h3
	} ffac_bit_st_t;

	typedef enum logic [3:0] {
		ffac_s_idle = 4'h0,
		ffac_s_start = 4'h1,
		ffac_s_devw = 4'h2,
		ffac_s_reg = 4'h3,
		ffac_s_data = 4'h4,
		ffac_s_rstart = 4'h5,
		ffac_s_devr = 4'h6,
		ffac_s_read = 4'h7,
		ffac_s_stop = 4'h8
	} ffac_seq_st_t;

	typedef struct packed {
		ffac_bit_st_t st;
		logic [1:0] ph;
		logic [15:0] cnt;
		logic [3:0] nbit;
		logic [8:0] tx;
		logic [8:0] rx;
		logic scl_lo;
		logic sda_lo;
		logic done;
		logic sda_s1;
		logic sda_s2;
		logic scl_s1;
		logic scl_s2;
	} ffac_bit_t;

	typedef struct packed {
		logic wr;
		logic hdr;
		logic acc;
		logic aux;
		logic tag1;
		logic tag2;
		logic tframe;
		logic drop;
	} ffac_frame_t;

	typedef struct packed {
		logic [7:0] options;
		logic [7:0] content;
		logic [7:0] target;
		logic [7:0] port;
		logic [7:0] rd_ptr;
		logic [7:0] wr_ptr;
		logic [7:0] wr_byte;
		logic [7:0] poll;
		logic [31:0] prdata;
		logic slverr;
		ffac_seq_st_t st;
		logic issued;
		logic is_read;
		logic failed;
		logic pend_wr;
		logic pend_rd;
		logic nack_err;
		logic [3:0] cnt;
		logic [31:0] poll_cnt;
		logic [7:0] last_byte;
		logic byte_valid;
		logic byte_last;
		logic sample_done;
	} ffac_top_t;

endpackage

// file: rtl/ffac_i2c_bit.sv
`timescale 1ns/1ns
`include "ffac_params.svh"
module ffac_i2c_bit #(
	parameter int unsigned QUARTER = `FFAC_QUARTER_CYCLES
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// byte level command
	input wire logic op_valid,
	input wire ffac_pkg::ffac_op_t op,
	input wire logic [7:0] op_byte,
	input wire logic op_read,
	input wire logic op_last,
	output logic op_ready,
	output logic op_done,
	output logic [7:0] rd_byte,
	output logic got_nack,
	// open-drain pins
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe
);
	localparam logic [15:0] QTR = 16'(QUARTER - 1);
	ffac_pkg::ffac_bit_t s;
	ffac_pkg::ffac_bit_t n;

	always_comb begin
		n = s;
		n.done = 1'b0;
		n.sda_s1 = sda_i;
		n.sda_s2 = s.sda_s1;
		n.scl_s1 = scl_i;
		n.scl_s2 = s.scl_s1;
		if (s.st == ffac_pkg::ffac_b_idle) begin
			if (op_valid) begin
				n.ph = 2'h0;
				n.cnt = QTR;
				n.nbit = 4'h0;
				n.rx = 9'h000;
				// read sends ack low except on the last byte
				n.tx = op_read ? {8'hff, op_last} : {op_byte, 1'b1};
				case (op)
				ffac_pkg::ffac_op_start: n.st = ffac_pkg::ffac_b_start;
				ffac_pkg::ffac_op_stop: n.st = ffac_pkg::ffac_b_stop;
				default: n.st = ffac_pkg::ffac_b_bits;
				endcase
			end
		end else if (s.cnt != 16'h0000) begin
			n.cnt = s.cnt - 16'h0001;
		end else if (s.ph == 2'h2 && !s.scl_s2) begin
			// a target stretching the clock holds start, stop and bits here
			n.cnt = QTR;
		end else begin
			n.cnt = QTR;
			n.ph = s.ph + 2'h1;
			case (s.st)
			ffac_pkg::ffac_b_start: begin
				case (s.ph)
				2'h0: n.sda_lo = 1'b0;
				2'h1: n.scl_lo = 1'b0;
				2'h2: n.sda_lo = 1'b1;
				default: n.scl_lo = 1'b1;
				endcase
			end
			ffac_pkg::ffac_b_stop: begin
				case (s.ph)
				2'h0: n.sda_lo = 1'b1;
				2'h1: n.scl_lo = 1'b0;
				2'h2: n.sda_lo = 1'b0;
				default: ;
				endcase
			end
			default: begin
				case (s.ph)
				2'h0: n.sda_lo = ~s.tx[8];
				2'h1: n.scl_lo = 1'b0;
				2'h2: n.rx = {s.rx[7:0], s.sda_s2};
				default: begin
					n.scl_lo = 1'b1;
					n.tx = {s.tx[7:0], 1'b1};
					n.nbit = s.nbit + 4'h1;
					if (s.nbit != 4'h8) begin
						n.ph = 2'h0;
					end
				end
				endcase
			end
			endcase
			if (s.ph == 2'h3 && (s.st != ffac_pkg::ffac_b_bits ||
					s.nbit == 4'h8)) begin
				n.st = ffac_pkg::ffac_b_idle;
				n.done = 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign op_ready = (s.st == ffac_pkg::ffac_b_idle);
	assign op_done = s.done;
	assign rd_byte = s.rx[8:1];
	assign got_nack = s.rx[0];
	assign scl_o = 1'b0;
	assign scl_oe = s.scl_lo;
	assign sda_o = 1'b0;
	assign sda_oe = s.sda_lo;
endmodule

// file: rtl/ffac_frame_gate.sv
`timescale 1ns/1ns
module ffac_frame_gate (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// configuration
	input wire logic stop_on_full,
	input wire logic time_en,
	input wire logic header_en,
	input wire logic acc_en,
	input wire logic aux_en,
	input wire logic tag_line_one_on,
	input wire logic tag_line_two_on,
	// sources and fifo state
	input wire logic acc_valid,
	input wire logic aux_valid,
	input wire logic fifo_full,
	input wire logic last_frame_read,
	input wire logic int_one_level,
	input wire logic int_two_level,
	// frame strobe and contents
	output logic frame_wr,
	output logic frame_hdr,
	output logic frame_acc,
	output logic frame_aux,
	output logic frame_tag_one,
	output logic frame_tag_two,
	output logic frame_time,
	output logic frame_drop
);
	ffac_pkg::ffac_frame_t s;
	ffac_pkg::ffac_frame_t n;
	logic take_acc;
	logic take_aux;
	logic ready;
	logic blocked;

	always_comb begin
		take_acc = acc_valid & acc_en;
		take_aux = aux_valid & aux_en;
		// headerless frames only make sense when every enabled source is present
		if (header_en) begin
			ready = take_acc | take_aux;
		end else begin
			ready = (acc_valid | ~acc_en) & (aux_valid | ~aux_en) &
				(acc_en | aux_en);
		end
		blocked = fifo_full & stop_on_full;
		n.wr = ready & ~blocked;
		n.drop = ready & blocked;
		n.hdr = ready & header_en;
		n.acc = ready & take_acc;
		n.aux = ready & take_aux;
		n.tag1 = ready & tag_line_one_on & int_one_level;
		n.tag2 = ready & tag_line_two_on & int_two_level;
		n.tframe = last_frame_read & time_en;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign frame_wr = s.wr;
	assign frame_hdr = s.hdr;
	assign frame_acc = s.acc;
	assign frame_aux = s.aux;
	assign frame_tag_one = s.tag1;
	assign frame_tag_two = s.tag2;
	assign frame_time = s.tframe;
	assign frame_drop = s.drop;
endmodule

// file: rtl/ffac_top.sv
`timescale 1ns/1ns
`include "ffac_params.svh"
// Functional notes
// - full fifo with halt set stops writes
// - time frame follows last read data frame
// - header per frame when enabled; else equal rates
// - accel enable stores all three axes
// - aux enable stores all three axes
// - two independent interrupt tag enables
// - target address in bits seven to one
// - burst code gives 1, 2, 6, 8 bytes
// - manual bit selects setup mode, resets one
// - read pointer selects target register, resets 42h
// - write pointer selects target register, resets 4Ch
// - write byte holds outgoing data, resets 02h
// - data mode polls at four-bit rate code
module ffac_top #(
	parameter int unsigned POLL_BASE_CYCLES = `FFAC_POLL_BASE_CYCLES,
	parameter int unsigned QUARTER = `FFAC_QUARTER_CYCLES
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	// fifo side
	input wire logic acc_sample_valid,
	input wire logic fifo_full,
	input wire logic fifo_last_read,
	input wire logic int_one_level,
	input wire logic int_two_level,
	output logic frame_wr,
	output logic frame_header,
	output logic frame_acc,
	output logic frame_aux,
	output logic frame_tag_one,
	output logic frame_tag_two,
	output logic frame_time,
	output logic frame_drop,
	// bytes read from the auxiliary target
	output logic [7:0] aux_byte,
	output logic aux_byte_valid,
	output logic aux_byte_last,
	// auxiliary i2c pins, open drain
	input wire logic aux_scl_i,
	output logic aux_scl_o,
	output logic aux_scl_oe,
	input wire logic aux_sda_i,
	output logic aux_sda_o,
	output logic aux_sda_oe
);
	localparam ffac_pkg::ffac_top_t RST = '{
		options: `FFAC_RST_FRAME_OPTIONS,
		content: `FFAC_RST_FRAME_CONTENT,
		target: `FFAC_RST_TARGET_ADDRESS,
		port: `FFAC_RST_PORT_SETUP,
		rd_ptr: `FFAC_RST_READ_POINTER,
		wr_ptr: `FFAC_RST_WRITE_POINTER,
		wr_byte: `FFAC_RST_WRITE_BYTE,
		poll: `FFAC_RST_POLL_SETUP,
		st: ffac_pkg::ffac_s_idle,
		default: '0
	};

	ffac_pkg::ffac_top_t s;
	ffac_pkg::ffac_top_t n;

	logic op_valid;
	ffac_pkg::ffac_op_t op;
	logic [7:0] op_byte;
	logic op_read;
	logic op_last;
	logic op_ready;
	logic op_done;
	logic [7:0] rd_byte;
	logic got_nack;

	logic setup_ph;
	logic access_ph;
	logic hit;
	logic [31:0] rd_word;
	logic manual;
	logic busy;
	logic [3:0] burst_len;
	logic last_in_burst;
	logic [3:0] code;
	logic poll_on;
	logic [31:0] period;
	logic poll_tick;
	logic set_wr;
	logic set_rd;
	logic clr_nack;
	logic set_nack;

	assign manual = s.port[`FFAC_BIT_MANUAL];
	assign busy = (s.st != ffac_pkg::ffac_s_idle);
	assign setup_ph = psel & ~penable;
	assign access_ph = psel & penable;

	always_comb begin
		case (s.port[1:0])
		2'h0: burst_len = `FFAC_BURST_L0;
		2'h1: burst_len = `FFAC_BURST_L1;
		2'h2: burst_len = `FFAC_BURST_L2;
		default: burst_len = `FFAC_BURST_L3;
		endcase
	end

	assign last_in_burst = (s.cnt == burst_len - 4'h1);

	// register read mux and decode
	always_comb begin
		rd_word = 32'h0000_0000;
		hit = 1'b1;
		case (paddr[11:2])
		`FFAC_IDX_FRAME_OPTIONS: rd_word[7:0] = s.options;
		`FFAC_IDX_FRAME_CONTENT: rd_word[7:0] = s.content;
		`FFAC_IDX_TARGET_ADDRESS: rd_word[7:0] = s.target;
		`FFAC_IDX_PORT_SETUP: rd_word[7:0] = s.port;
		`FFAC_IDX_READ_POINTER: rd_word[7:0] = s.rd_ptr;
		`FFAC_IDX_WRITE_POINTER: rd_word[7:0] = s.wr_ptr;
		`FFAC_IDX_WRITE_BYTE: rd_word[7:0] = s.wr_byte;
		`FFAC_IDX_POLL_SETUP: rd_word[7:0] = s.poll;
		`FFAC_IDX_PORT_STATUS: begin
			rd_word[15:8] = s.last_byte;
			rd_word[`FFAC_BIT_ST_BUSY] = busy;
			rd_word[`FFAC_BIT_ST_NACK] = s.nack_err;
			rd_word[`FFAC_BIT_ST_PEND] = s.pend_wr | s.pend_rd;
		end
		default: hit = 1'b0;
		endcase
		if (paddr[1:0] != 2'h0) begin
			hit = 1'b0;
		end
	end

	// poll timer, fastest code has the base period
	always_comb begin
		code = s.poll[3:0];
		poll_on = ~manual && code >= `FFAC_ODR_MIN &&
			code <= `FFAC_ODR_MAX;
		period = 32'(POLL_BASE_CYCLES) << (`FFAC_ODR_MAX - code);
		poll_tick = poll_on && (s.poll_cnt >= period - 32'h0000_0001);
	end

	// commands to the bit engine
	always_comb begin
		op = ffac_pkg::ffac_op_byte;
		op_byte = 8'h00;
		op_read = 1'b0;
		op_last = 1'b0;
		case (s.st)
		ffac_pkg::ffac_s_start: op = ffac_pkg::ffac_op_start;
		ffac_pkg::ffac_s_rstart: op = ffac_pkg::ffac_op_start;
		ffac_pkg::ffac_s_stop: op = ffac_pkg::ffac_op_stop;
		ffac_pkg::ffac_s_devw: op_byte = {s.target[7:1], 1'b0};
		ffac_pkg::ffac_s_reg: begin
			op_byte = s.is_read ? s.rd_ptr : s.wr_ptr;
		end
		ffac_pkg::ffac_s_data: op_byte = s.wr_byte;
		ffac_pkg::ffac_s_devr: op_byte = {s.target[7:1], 1'b1};
		ffac_pkg::ffac_s_read: begin
			op_read = 1'b1;
			op_last = last_in_burst;
		end
		default: ;
		endcase
		op_valid = busy & ~s.issued;
	end

	always_comb begin
		n = s;
		n.byte_valid = 1'b0;
		n.byte_last = 1'b0;
		n.sample_done = 1'b0;
		set_wr = 1'b0;
		set_rd = 1'b0;
		clr_nack = 1'b0;
		set_nack = 1'b0;

		// apb: answer is prepared in setup, so access needs no wait
		if (setup_ph) begin
			n.prdata = pwrite ? 32'h0000_0000 : rd_word;
			n.slverr = ~hit;
		end
		if (access_ph && pwrite && hit) begin
			case (paddr[11:2])
			`FFAC_IDX_FRAME_OPTIONS: begin
				n.options = pwdata[7:0] & `FFAC_MASK_FRAME_OPTIONS;
			end
			`FFAC_IDX_FRAME_CONTENT: begin
				n.content = pwdata[7:0] & `FFAC_MASK_FRAME_CONTENT;
			end
			`FFAC_IDX_TARGET_ADDRESS: begin
				n.target = pwdata[7:0] & `FFAC_MASK_TARGET_ADDRESS;
			end
			`FFAC_IDX_PORT_SETUP: begin
				n.port = pwdata[7:0] & `FFAC_MASK_PORT_SETUP;
			end
			`FFAC_IDX_READ_POINTER: begin
				n.rd_ptr = pwdata[7:0];
				set_rd = manual;
			end
			`FFAC_IDX_WRITE_POINTER: begin
				n.wr_ptr = pwdata[7:0];
			end
			`FFAC_IDX_WRITE_BYTE: begin
				n.wr_byte = pwdata[7:0];
				set_wr = manual;
			end
			`FFAC_IDX_POLL_SETUP: begin
				n.poll = pwdata[7:0] & `FFAC_MASK_FULL;
			end
			`FFAC_IDX_PORT_STATUS: begin
				clr_nack = pwdata[`FFAC_BIT_ST_NACK];
			end
			default: ;
			endcase
		end

		// poll counter
		if (!poll_on || poll_tick) begin
			n.poll_cnt = 32'h0000_0000;
		end else begin
			n.poll_cnt = s.poll_cnt + 32'h0000_0001;
		end
		if (poll_tick) begin
			set_rd = 1'b1;
		end

		// transaction sequencer
		if (op_valid && op_ready) begin
			n.issued = 1'b1;
		end
		if (op_done) begin
			n.issued = 1'b0;
			case (s.st)
			ffac_pkg::ffac_s_start: n.st = ffac_pkg::ffac_s_devw;
			ffac_pkg::ffac_s_devw: begin
				n.st = got_nack ? ffac_pkg::ffac_s_stop : ffac_pkg::ffac_s_reg;
				set_nack = got_nack;
			end
			ffac_pkg::ffac_s_reg: begin
				if (got_nack) begin
					n.st = ffac_pkg::ffac_s_stop;
				end else if (s.is_read) begin
					n.st = ffac_pkg::ffac_s_rstart;
				end else begin
					n.st = ffac_pkg::ffac_s_data;
				end
				set_nack = got_nack;
			end
			ffac_pkg::ffac_s_data: begin
				n.st = ffac_pkg::ffac_s_stop;
				set_nack = got_nack;
			end
			ffac_pkg::ffac_s_rstart: n.st = ffac_pkg::ffac_s_devr;
			ffac_pkg::ffac_s_devr: begin
				n.st = got_nack ? ffac_pkg::ffac_s_stop : ffac_pkg::ffac_s_read;
				set_nack = got_nack;
			end
			ffac_pkg::ffac_s_read: begin
				n.last_byte = rd_byte;
				n.byte_valid = 1'b1;
				n.byte_last = last_in_burst;
				if (last_in_burst) begin
					n.st = ffac_pkg::ffac_s_stop;
				end else begin
					n.cnt = s.cnt + 4'h1;
				end
			end
			ffac_pkg::ffac_s_stop: begin
				n.st = ffac_pkg::ffac_s_idle;
				// only a clean burst in data mode feeds the fifo
				n.sample_done = s.is_read & ~manual & ~s.failed;
			end
			default: n.st = ffac_pkg::ffac_s_idle;
			endcase
		end
		if (set_nack) begin
			n.failed = 1'b1;
		end

		// launch: a pending write goes before a pending read
		if (!busy) begin
			if (s.pend_wr) begin
				n.pend_wr = 1'b0;
				n.is_read = 1'b0;
				n.failed = 1'b0;
				n.cnt = 4'h0;
				n.st = ffac_pkg::ffac_s_start;
			end else if (s.pend_rd) begin
				n.pend_rd = 1'b0;
				n.is_read = 1'b1;
				n.failed = 1'b0;
				n.cnt = 4'h0;
				n.st = ffac_pkg::ffac_s_start;
			end
		end

		// a set in the same cycle as a clear wins
		if (set_wr) begin
			n.pend_wr = 1'b1;
		end
		if (set_rd) begin
			n.pend_rd = 1'b1;
		end
		if (clr_nack) begin
			n.nack_err = 1'b0;
		end
		if (set_nack) begin
			n.nack_err = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= RST;
		end else begin
			s <= n;
		end
	end

	ffac_i2c_bit #(
		.QUARTER(QUARTER)
	) u_bit (
		.pclk(pclk),
		.presetn(presetn),
		.op_valid(op_valid),
		.op(op),
		.op_byte(op_byte),
		.op_read(op_read),
		.op_last(op_last),
		.op_ready(op_ready),
		.op_done(op_done),
		.rd_byte(rd_byte),
		.got_nack(got_nack),
		.scl_i(aux_scl_i),
		.scl_o(aux_scl_o),
		.scl_oe(aux_scl_oe),
		.sda_i(aux_sda_i),
		.sda_o(aux_sda_o),
		.sda_oe(aux_sda_oe)
	);

	ffac_frame_gate u_gate (
		.pclk(pclk),
		.presetn(presetn),
		.stop_on_full(s.options[`FFAC_BIT_STOP_ON_FULL]),
		.time_en(s.options[`FFAC_BIT_TIME_EN]),
		.header_en(s.content[`FFAC_BIT_HEADER_EN]),
		.acc_en(s.content[`FFAC_BIT_ACC_EN]),
		.aux_en(s.content[`FFAC_BIT_AUX_EN]),
		.tag_line_one_on(s.content[`FFAC_BIT_TAG_ONE]),
		.tag_line_two_on(s.content[`FFAC_BIT_TAG_TWO]),
		.acc_valid(acc_sample_valid),
		.aux_valid(s.sample_done),
		.fifo_full(fifo_full),
		.last_frame_read(fifo_last_read),
		.int_one_level(int_one_level),
		.int_two_level(int_two_level),
		.frame_wr(frame_wr),
		.frame_hdr(frame_header),
		.frame_acc(frame_acc),
		.frame_aux(frame_aux),
		.frame_tag_one(frame_tag_one),
		.frame_tag_two(frame_tag_two),
		.frame_time(frame_time),
		.frame_drop(frame_drop)
	);

	assign pready = 1'b1;
	assign prdata = s.prdata;
	assign pslverr = s.slverr;
	assign aux_byte = s.last_byte;
	assign aux_byte_valid = s.byte_valid;
	assign aux_byte_last = s.byte_last;
endmodule

// file: tb/ffac_checker.sv
`timescale 1ns/1ns
module ffac_checker (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// fifo side inputs
	input wire logic acc_sample_valid,
	input wire logic fifo_full,
	input wire logic fifo_last_read,
	input wire logic int_one_level,
	input wire logic int_two_level,
	// frame outputs
	input wire logic frame_wr,
	input wire logic frame_acc,
	input wire logic frame_tag_one,
	input wire logic frame_tag_two,
	input wire logic frame_time,
	input wire logic frame_drop,
	// auxiliary bytes
	input wire logic aux_byte_valid,
	input wire logic aux_byte_last
);
	logic [3:0] nb;
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// bytes seen in the current burst
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			nb <= 4'h0;
		else if (aux_byte_valid)
			nb <= aux_byte_last ? 4'h0 : nb + 4'h1;
	end
	property p_excl;
		!(frame_wr && frame_drop);
	endproperty
	property p_drop;
		frame_drop |-> $past(fifo_full);
	endproperty
	property p_time;
		frame_time |-> $past(fifo_last_read);
	endproperty
	property p_acc;
		frame_wr && frame_acc |-> $past(acc_sample_valid);
	endproperty
	property p_tag1;
		frame_wr && frame_tag_one |-> $past(int_one_level);
	endproperty
	property p_tag2;
		frame_wr && frame_tag_two |-> $past(int_two_level);
	endproperty
	property p_last;
		aux_byte_last |-> aux_byte_valid;
	endproperty
	property p_len;
		aux_byte_valid && !aux_byte_last |-> nb < 4'h7;
	endproperty
	a_excl: assert property (p_excl)
		else $error("write and drop together");
	a_drop: assert property (p_drop)
		else $error("drop without full");
	a_time: assert property (p_time)
		else $error("time frame without last read");
	a_acc: assert property (p_acc)
		else $error("accel frame without sample");
	a_tag1: assert property (p_tag1)
		else $error("tag one without level");
	a_tag2: assert property (p_tag2)
		else $error("tag two without level");
	a_last: assert property (p_last)
		else $error("last without valid");
	a_len: assert property (p_len)
		else $error("burst longer than eight");
	c_drop: cover property (frame_drop);
	c_time: cover property (frame_time);
	c_b8: cover property (aux_byte_last && nb == 4'h7);
endmodule

bind ffac_top ffac_checker chk_u (
	.pclk(pclk), .presetn(presetn), .acc_sample_valid(acc_sample_valid),
	.fifo_full(fifo_full), .fifo_last_read(fifo_last_read),
	.int_one_level(int_one_level), .int_two_level(int_two_level),
	.frame_wr(frame_wr), .frame_acc(frame_acc),
	.frame_tag_one(frame_tag_one), .frame_tag_two(frame_tag_two),
	.frame_time(frame_time), .frame_drop(frame_drop),
	.aux_byte_valid(aux_byte_valid), .aux_byte_last(aux_byte_last)
);

// file: tb/ffac_aux_target.sv
`timescale 1ns/1ns
module ffac_aux_target #(
	parameter logic [6:0] ADDR = 7'h1d,
	parameter logic [7:0] BASE = 8'h5a
) (
	// bus lines, pulled up outside
	input wire logic scl,
	input wire logic sda,
	// pacing
	input wire logic slow,
	output logic scl_oe,
	output logic sda_oe
);
	logic [7:0] sh, tx;
	logic act, rd, first, ack_ph, nack;
	int n;
	logic [7:0] got[$];
	initial begin
		scl_oe = 1'b0;
		sda_oe = 1'b0;
		act = 1'b0;
	end
	always @(negedge sda) if (scl === 1'b1) begin
		{act, first} = 2'h3;
		{rd, ack_ph, nack} = 3'h0;
		n = 0;
	end
	always @(posedge sda) if (scl === 1'b1) act = 1'b0;
	always @(posedge scl) if (act) begin
		if (ack_ph) nack = sda;
		else begin
			sh = {sh[6:0], sda};
			n++;
		end
	end
	// data changes only while the clock line is low
	always @(negedge scl) if (act) begin
		if (ack_ph) begin
			ack_ph = 1'b0;
			n = 0;
			sda_oe = rd && !nack && !tx[7];
			act = !(rd && nack);
		end else if (n == 8) begin
			ack_ph = 1'b1;
			if (first) begin
				first = 1'b0;
				rd = sh[0];
				tx = BASE;
				sda_oe = sh[7:1] == ADDR;
				act = sda_oe;
			end else begin
				sda_oe = !rd;
				if (!rd) got.push_back(sh);
				tx = tx + 8'h01;
			end
		end else sda_oe = rd && !tx[7 - n];
	end
	// a busy target stretches the low phase
	always @(negedge scl) if (act && slow) begin
		scl_oe = 1'b1;
		#300;
		scl_oe = 1'b0;
	end
endmodule

// file: tb/fifo_frame_and_aux_master_cfg_tb_top.sv
`timescale 1ns/1ns
module fifo_frame_and_aux_master_cfg_tb_top;
	localparam logic [6:0] TADDR = 7'h1d;
	localparam logic [7:0] BASE = 8'h5a;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic acc_v, full, lastr, i1, i2, slow;
	logic f_wr, f_hdr, f_acc, f_aux, f_t1, f_t2, f_time, f_drop;
	logic [7:0] ab;
	logic abv, abl, scl_oe, sda_oe, t_scl_oe, t_sda_oe;
	wire logic scl = !(scl_oe | t_scl_oe);
	wire logic sda = !(sda_oe | t_sda_oe);
	int fails, checks, naux, nlast;
	logic [7:0] rx[$];
	logic [11:0] ra[7] = '{12'h120, 12'h124, 12'h12c, 12'h130, 12'h134,
		12'h138, 12'h13c};
	logic [7:0] rv[7] = '{8'h02, 8'h10, 8'h20, 8'h83, 8'h42, 8'h4c, 8'h02};
	logic [7:0] wm[4] = '{8'h03, 8'h7c, 8'hfe, 8'h83};
	int bl[4] = '{1, 2, 6, 8};
	ffac_top #(.POLL_BASE_CYCLES(200), .QUARTER(4)) dut_u (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .acc_sample_valid(acc_v),
		.fifo_full(full), .fifo_last_read(lastr), .int_one_level(i1),
		.int_two_level(i2), .frame_wr(f_wr), .frame_header(f_hdr),
		.frame_acc(f_acc), .frame_aux(f_aux), .frame_tag_one(f_t1),
		.frame_tag_two(f_t2), .frame_time(f_time), .frame_drop(f_drop),
		.aux_byte(ab), .aux_byte_valid(abv), .aux_byte_last(abl),
		.aux_scl_i(scl), .aux_scl_o(), .aux_scl_oe(scl_oe),
		.aux_sda_i(sda), .aux_sda_o(), .aux_sda_oe(sda_oe)
	);
	ffac_aux_target #(.ADDR(TADDR), .BASE(BASE)) tgt_u (
		.scl(scl), .sda(sda), .slow(slow), .scl_oe(t_scl_oe),
		.sda_oe(t_sda_oe)
	);
	always #4 pclk = ~pclk;
	always @(posedge pclk) begin
		if (abv === 1'b1) rx.push_back(ab);
		if (abl === 1'b1) nlast = rx.size();
		if (f_wr === 1'b1 && f_aux === 1'b1) naux++;
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			fails++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [7:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h00_0000, d};
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 64);
		if (n >= 64) fails++;
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 8'h00);
		chk(q, e);
	endtask
	// status polling, so slow targets never trip a fixed wait
	task automatic idle;
		int n;
		n = 0;
		repeat (8) @(posedge pclk);
		do begin
			apb(1'b0, 12'h180, 8'h00);
			n++;
		end while ((q[0] || q[2]) && n < 3000);
		if (n >= 3000) fails++;
	endtask
	task automatic frm(input logic [7:0] o, c, input logic fu, a, b);
		logic wr;
		apb(1'b1, 12'h120, o);
		apb(1'b1, 12'h124, c);
		@(posedge pclk);
		acc_v <= 1'b1;
		full <= fu;
		i1 <= a;
		i2 <= b;
		lastr <= 1'b1;
		@(posedge pclk);
		acc_v <= 1'b0;
		lastr <= 1'b0;
		#1;
		wr = c[6] && !(fu && o[0]);
		chk({f_wr, f_drop, f_time}, {wr, c[6] & fu & o[0], o[1]});
		if (wr) chk({f_hdr, f_acc, f_t1, f_t2}, {c[4], 1'b1, c[3] & a, c[2] & b});
	endtask
	task automatic end_sim;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		{psel, penable, pwrite, acc_v, full, lastr, i1, i2, slow} = '0;
		paddr = '0;
		pwdata = '0;
		{fails, checks, naux, nlast} = '0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		foreach (ra[i]) rd(ra[i], rv[i]);
		rd(12'h200, 32'h0000_0000);
		chk(err, 1'b1);
		foreach (wm[i]) begin
			apb(1'b1, ra[i], 8'hff);
			rd(ra[i], wm[i]);
		end
		frm(8'h00, 8'h58, 1'b1, 1'b1, 1'b1);
		frm(8'h03, 8'h44, 1'b0, 1'b1, 1'b1);
		frm(8'h01, 8'h5c, 1'b1, 1'b1, 1'b0);
		frm(8'h02, 8'h10, 1'b0, 1'b1, 1'b1);
		apb(1'b1, 12'h12c, {TADDR, 1'b1});
		rd(12'h12c, {TADDR, 1'b0});
		apb(1'b1, 12'h138, 8'h3c);
		apb(1'b1, 12'h13c, 8'h99);
		idle();
		chk({tgt_u.got[$ - 1], tgt_u.got[$]}, 16'h3c99);
		for (int k = 0; k < 4; k++) begin
			slow = k[1];
			apb(1'b1, 12'h130, {6'h20, k[1:0]});
			rx.delete();
			apb(1'b1, 12'h134, 8'h30 + k[7:0]);
			idle();
			chk(rx.size(), bl[k]);
			chk(nlast, bl[k]);
			chk(tgt_u.got[$], 8'h30 + k[7:0]);
			foreach (rx[j]) chk(rx[j], BASE + j[7:0]);
		end
		// polls run back to back below, so the target must not stretch
		slow = 1'b0;
		apb(1'b1, 12'h12c, 8'h00);
		apb(1'b1, 12'h13c, 8'h11);
		idle();
		chk(q[1], 1'b1);
		apb(1'b1, 12'h180, 8'h02);
		apb(1'b0, 12'h180, 8'h00);
		chk(q[1], 1'b0);
		apb(1'b1, 12'h12c, {TADDR, 1'b0});
		apb(1'b1, 12'h124, 8'h30);
		apb(1'b1, 12'h110, 8'h0b);
		apb(1'b1, 12'h130, 8'h00);
		naux = 0;
		repeat (3000) @(posedge pclk);
		chk(naux >= 2, 1'b1);
		apb(1'b1, 12'h124, 8'h10);
		repeat (2) @(posedge pclk);
		naux = 0;
		repeat (2000) @(posedge pclk);
		chk(naux, 0);
		apb(1'b1, 12'h130, 8'h80);
		idle();
		end_sim();
	end
	initial begin
		#700_000;
		fails++;
		end_sim();
	end
endmodule
